// File: rtl/kpw_pkg.sv
// package for the keypad level wake input block
// assumes an 8-bit special function register port on the core clock
package kpw_pkg;
   // --------------------------------------------------------------
   // register offsets
   // --------------------------------------------------------------
   localparam logic [7:0] KPW_ADDR_AUX_CONTROL = 8'h90;
   localparam logic [7:0] KPW_ADDR_KEYPAD_CONTROL = 8'hA3;
   localparam logic [7:0] KPW_ADDR_KEYPAD_STATUS = 8'hA4;
   // --------------------------------------------------------------
   // field positions and reset values
   // --------------------------------------------------------------
   localparam int KPW_CTL_LEVEL_BIT = 4;
   localparam int KPW_CTL_MASK_BIT = 0;
   localparam int KPW_STA_FLAG_BIT = 0;
   localparam int KPW_STA_PDWAKE_BIT = 7;
   localparam int KPW_AUX_PIN_BIT = 0;
   localparam logic [7:0] KPW_RST_AUX_CONTROL = 8'hFF;
   localparam logic [7:0] KPW_RST_KEYPAD_CONTROL = 8'h0F;
   localparam logic [7:0] KPW_RST_KEYPAD_STATUS = 8'h00;
   localparam logic [7:0] KPW_CTL_WMASK = 8'h11;
   localparam logic [7:0] KPW_CTL_FIXED = 8'h0E;
   localparam logic [7:0] KPW_AUX_WMASK = 8'hFE;
endpackage

// File: rtl/kpw_keypad_wake.sv
// keypad level wake input: one keypad pin, its control and status registers
// assumes the core presents sfr reads and writes as one-cycle strobes on i_ref_clk
`timescale 1ns/1ps
module kpw_keypad_wake
   import kpw_pkg::*;
(
   // clock and reset
   input wire logic i_ref_clk,
   input wire logic i_arst_n,
   // keypad pin
   input wire logic i_keypad_input_pin,
   // special function register port
   input wire logic [7:0] i_sfr_addr,
   input wire logic i_sfr_wr,
   input wire logic i_sfr_rd,
   input wire logic [7:0] i_sfr_wdata,
   output logic [7:0] o_sfr_rdata,
   // from the interrupt enable register and power manager
   input wire logic i_key_irq_global_en,
   input wire logic i_powerdown,
   // towards core and power manager
   output logic o_key_irq,
   output logic o_idle_wake,
   output logic o_pd_wake
);
   import kpw_pkg::*;

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   logic pin_meta;
   logic pin_sync;
   logic next_pin_meta;
   logic next_pin_sync;

   // the first stage feeds only the second stage
   always_comb begin
      next_pin_meta = i_keypad_input_pin;
      next_pin_sync = pin_meta;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         pin_meta <= 1'b1;
         pin_sync <= 1'b1;
      end else begin
         pin_meta <= next_pin_meta;
         pin_sync <= next_pin_sync;
      end
   end

   // ---------------------------------------------------------------
   // registers
   // ---------------------------------------------------------------
   logic [7:0] aux_control;
   logic [7:0] keypad_control;
   logic key_detect_flag;
   logic key_powerdown_wake_en;
   logic [7:0] next_aux_control;
   logic [7:0] next_keypad_control;
   logic next_key_detect_flag;
   logic next_key_powerdown_wake_en;
   logic key_level_select;
   logic key_irq_mask;
   logic level_hit;
   logic status_read;

   function automatic logic sel(input logic [7:0] addr, input logic [7:0] reg_addr);
      sel = (addr == reg_addr);
   endfunction

   assign key_level_select = keypad_control[KPW_CTL_LEVEL_BIT];
   assign key_irq_mask = keypad_control[KPW_CTL_MASK_BIT];
   // high level when select is one, low level otherwise
   assign level_hit = key_level_select ? pin_sync : !pin_sync;
   assign status_read = i_sfr_rd && sel(i_sfr_addr, KPW_ADDR_KEYPAD_STATUS);

   // next register values; a detection in the read cycle wins over the clear
   always_comb begin
      next_aux_control = aux_control;
      next_keypad_control = keypad_control;
      next_key_powerdown_wake_en = key_powerdown_wake_en;
      next_key_detect_flag = key_detect_flag;
      if (status_read) begin
         next_key_detect_flag = 1'b0;
      end
      if (level_hit) begin
         next_key_detect_flag = 1'b1;
      end
      if (i_sfr_wr && sel(i_sfr_addr, KPW_ADDR_KEYPAD_CONTROL)) begin
         // reserved bits hold their fixed values whatever software writes
         next_keypad_control = (i_sfr_wdata & KPW_CTL_WMASK) | KPW_CTL_FIXED;
      end
      if (i_sfr_wr && sel(i_sfr_addr, KPW_ADDR_KEYPAD_STATUS)) begin
         next_key_powerdown_wake_en = i_sfr_wdata[KPW_STA_PDWAKE_BIT];
      end
      if (i_sfr_wr && sel(i_sfr_addr, KPW_ADDR_AUX_CONTROL)) begin
         // bit 0 mirrors the pin; the other bits belong to neighbouring blocks
         next_aux_control = (i_sfr_wdata & KPW_AUX_WMASK) | {7'h00, pin_sync};
      end else begin
         next_aux_control[KPW_AUX_PIN_BIT] = pin_sync;
      end
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         aux_control <= KPW_RST_AUX_CONTROL;
         keypad_control <= KPW_RST_KEYPAD_CONTROL;
         key_detect_flag <= KPW_RST_KEYPAD_STATUS[KPW_STA_FLAG_BIT];
         key_powerdown_wake_en <= KPW_RST_KEYPAD_STATUS[KPW_STA_PDWAKE_BIT];
      end else begin
         aux_control <= next_aux_control;
         keypad_control <= next_keypad_control;
         key_detect_flag <= next_key_detect_flag;
         key_powerdown_wake_en <= next_key_powerdown_wake_en;
      end
   end

   // ---------------------------------------------------------------
   // read data and interrupt outputs
   // ---------------------------------------------------------------
   logic [7:0] next_sfr_rdata;
   logic next_key_irq;
   logic next_idle_wake;

   always_comb begin
      next_sfr_rdata = 8'h00;
      if (i_sfr_rd) begin
         if (sel(i_sfr_addr, KPW_ADDR_AUX_CONTROL)) begin
            next_sfr_rdata = aux_control;
         end else if (sel(i_sfr_addr, KPW_ADDR_KEYPAD_CONTROL)) begin
            next_sfr_rdata = keypad_control;
         end else if (sel(i_sfr_addr, KPW_ADDR_KEYPAD_STATUS)) begin
            // middle bits always read zero
            next_sfr_rdata = {key_powerdown_wake_en, 6'h00, key_detect_flag};
         end
      end
      // flag gated by local mask then global enable
      next_key_irq = key_detect_flag && !key_irq_mask && i_key_irq_global_en;
      next_idle_wake = next_key_irq && !i_powerdown;
   end

   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_sfr_rdata <= 8'h00;
         o_key_irq <= 1'b0;
         o_idle_wake <= 1'b0;
      end else begin
         o_sfr_rdata <= next_sfr_rdata;
         o_key_irq <= next_key_irq;
         o_idle_wake <= next_idle_wake;
      end
   end

   // ---------------------------------------------------------------
   // power-down wake, clocked output and clockless raw-level term
   // ---------------------------------------------------------------
   // with clocks stopped the raw pin level must act directly; pd_wake_async
   // follows it combinationally but drives no output, while o_pd_wake waits for a clock edge
   logic raw_hit;
   logic pd_arm;
   assign raw_hit = key_level_select ? i_keypad_input_pin : !i_keypad_input_pin;
   assign pd_arm = i_powerdown && key_powerdown_wake_en && !key_irq_mask
                   && i_key_irq_global_en;

   // set from the synchronised level on a clock edge, cleared on the next edge once the arm or the level drops
   always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
      if (!i_arst_n) begin
         o_pd_wake <= 1'b0;
      end else begin
         o_pd_wake <= pd_arm && level_hit;
      end
   end

   // asynchronous wake request from the raw level; drives no output and is used only by a_async_wake
   logic pd_wake_async;
   assign pd_wake_async = pd_arm && raw_hit;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_hit_read;
      level_hit ##0 status_read;
   endsequence

   a_flag_sets: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      level_hit |=> key_detect_flag) else $error("flag not set on level");
   a_read_clears: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      status_read && !level_hit |=> !key_detect_flag) else $error("read left flag");
   a_set_wins: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      s_hit_read |=> key_detect_flag) else $error("clear beat set");
   a_high_level: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      key_level_select && pin_sync |=> key_detect_flag) else $error("high missed");
   a_low_level: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      !key_level_select && !pin_sync |=> key_detect_flag) else $error("low missed");
   a_mask_blocks: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      key_irq_mask |=> !o_key_irq) else $error("masked irq raised");
   a_global_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      o_key_irq |-> $past(i_key_irq_global_en)) else $error("irq without enable");
   a_irq_follows: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      key_detect_flag && !key_irq_mask && i_key_irq_global_en |=> o_key_irq)
      else $error("irq not raised");
   a_status_zero: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      $past(status_read) |-> o_sfr_rdata[6:1] == 6'h00) else $error("reserved set");
   a_ctl_fixed: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      keypad_control[3:1] == 3'h7 && keypad_control[7:5] == 3'h0)
      else $error("control reserved bits moved");
   a_pd_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      o_pd_wake |-> $past(key_powerdown_wake_en)) else $error("wake without enable");
   a_sync_delay: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      pin_sync == $past(i_keypad_input_pin, 2) || $past(!i_arst_n, 2))
      else $error("sync depth wrong");
   // built from the raw terms so that a broken arm or level term is caught
   a_async_wake: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      i_powerdown && key_powerdown_wake_en && !key_irq_mask && i_key_irq_global_en
      && (key_level_select == i_keypad_input_pin) |-> pd_wake_async)
      else $error("async wake missing");

   // ---------------------------------------------------------------
   // further checks on register writes and outputs
   // ---------------------------------------------------------------
   // register access steps, shared by the properties below
   sequence s_ctl_write;
      i_sfr_wr && sel(i_sfr_addr, KPW_ADDR_KEYPAD_CONTROL);
   endsequence

   sequence s_sta_write;
      i_sfr_wr && sel(i_sfr_addr, KPW_ADDR_KEYPAD_STATUS);
   endsequence

   sequence s_sta_read;
      status_read;
   endsequence

   // the two live control bits take the written value
   a_ctl_store: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      s_ctl_write |=> keypad_control[KPW_CTL_LEVEL_BIT] == $past(i_sfr_wdata[4])
      && keypad_control[KPW_CTL_MASK_BIT] == $past(i_sfr_wdata[0]))
      else $error("control write lost");
   // only bit 7 of a status write is stored
   a_wake_store: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      s_sta_write |=> key_powerdown_wake_en == $past(i_sfr_wdata[7]))
      else $error("wake enable write lost");
   // read data carries the flag as it stood before the clear
   a_read_flag: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      s_sta_read |=> o_sfr_rdata[0] == $past(key_detect_flag))
      else $error("status read data wrong");
   // with no read strobe the data lines sit at zero
   a_rdata_quiet: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      !$past(i_sfr_rd) |-> o_sfr_rdata == 8'h00)
      else $error("read data without read");
   // the flag is sticky until a read
   a_flag_holds: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      key_detect_flag && !status_read |=> key_detect_flag)
      else $error("flag dropped without read");
   // idle wake never outruns the interrupt request
   a_idle_gate: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      o_idle_wake |-> o_key_irq && $past(!i_powerdown))
      else $error("idle wake without request");
   // power-down wake needs power-down, no mask and the global enable; the wake enable is checked by a_pd_gate
   a_pd_enables: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      o_pd_wake |-> $past(i_powerdown && !key_irq_mask && i_key_irq_global_en))
      else $error("power-down wake while gated");
   // clocked wake follows an armed detection one edge later
   a_pd_sets: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      pd_arm && level_hit |=> o_pd_wake)
      else $error("power-down wake missed");
   // the pin mirror in aux_control uses the synchronised level only
   a_aux_mirror: assert property (@(posedge i_ref_clk) disable iff (!i_arst_n)
      aux_control[KPW_AUX_PIN_BIT] == $past(pin_sync))
      else $error("pin mirror wrong");
endmodule

// File: verification/kpw_keypad_switch.sv
// keypad switch model: one key on the keypad input pin
// assumes the bench says which level a pressed key shows
`timescale 1ns/1ps
module kpw_keypad_switch (
   // control from the bench
   input wire logic i_press,
   input wire logic i_active_high,
   // keypad pin
   output logic o_pin
);
   initial o_pin = 1'h1;
   // a real key chatters before it settles, so each press bounces once
   always @(i_press or i_active_high) begin
      if (i_press) begin
         o_pin = i_active_high;
         #7 o_pin = !i_active_high;
         #13 o_pin = i_active_high;
      end else begin
         o_pin = !i_active_high;
      end
   end
endmodule

// File: verification/kpw_keypad_wake_bench.sv
// self-checking bench for the keypad level wake input
// assumes the switch model drives the pin and the bench plays the core
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_tests++; if ((got) !== (exp)) begin err_count++; \
   $display("unexpected %s expected %h seen %h", nm, exp, got); end end
module kpw_keypad_wake_bench;
   import kpw_pkg::*;
   logic clk = 1'h0;
   logic rst_n = 1'h0;
   logic press = 1'h0;
   logic act_hi = 1'h0;
   logic wr = 1'h0;
   logic rd = 1'h0;
   logic gen = 1'h0;
   logic pd = 1'h0;
   logic [7:0] addr = 8'h00;
   logic [7:0] wdata = 8'h00;
   logic [7:0] lfsr = 8'h3D;
   logic [7:0] rdata;
   logic pin, irq, idle_wake, pd_wake;
   int err_count = 0;
   int n_tests = 0;
   int cycles = 0;
   // ----------------------------------------------------------------
   // clock, parts and helpers
   // ----------------------------------------------------------------
   always #25 clk = ~clk;
   kpw_keypad_switch key (.i_press(press), .i_active_high(act_hi), .o_pin(pin));
   kpw_keypad_wake dut (.i_ref_clk(clk), .i_arst_n(rst_n), .i_keypad_input_pin(pin),
      .i_sfr_addr(addr), .i_sfr_wr(wr), .i_sfr_rd(rd), .i_sfr_wdata(wdata),
      .o_sfr_rdata(rdata), .i_key_irq_global_en(gen), .i_powerdown(pd),
      .o_key_irq(irq), .o_idle_wake(idle_wake), .o_pd_wake(pd_wake));
   function automatic logic [7:0] next_rand(input logic [7:0] v);
      return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
   endfunction
   // control reads back with reserved bits pinned, whatever was written
   function automatic logic [7:0] exp_ctl(input logic [7:0] v);
      return (v & KPW_CTL_WMASK) | KPW_CTL_FIXED;
   endfunction
   // one strobe cycle; read data is taken in the cycle after the edge
   task automatic bus(input logic w, input logic [7:0] a, input logic [7:0] d,
      output logic [7:0] q);
      @(negedge clk);
      addr = a;
      wdata = d;
      wr = w;
      rd = !w;
      @(negedge clk);
      q = rdata;
      wr = 1'h0;
      rd = 1'h0;
   endtask
   task automatic rchk(input string nm, input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] q;
      bus(1'h0, a, 8'h00, q);
      `CHK(nm, exp, q)
   endtask
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", n_tests, err_count);
      if (err_count == 0 && n_tests > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // hang guard: the whole run needs well under this many cycles
   always @(posedge clk) begin
      cycles++;
      if (cycles == 4000) begin
         err_count++;
         report_and_stop();
      end
   end
   // ----------------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------------
   initial begin
      logic [7:0] q;
      logic [4:0] c;
      repeat (2) @(negedge clk);
      rst_n = 1'h1;
      rchk("aux", KPW_ADDR_AUX_CONTROL, KPW_RST_AUX_CONTROL);
      rchk("ctl", KPW_ADDR_KEYPAD_CONTROL, KPW_RST_KEYPAD_CONTROL);
      rchk("sta", KPW_ADDR_KEYPAD_STATUS, KPW_RST_KEYPAD_STATUS);
      rchk("gap", 8'h91, 8'h00);
      $display("reset test done");
      // random control writes, reserved bits kept as software must
      repeat (4) begin
         lfsr = next_rand(lfsr);
         bus(1'h1, KPW_ADDR_KEYPAD_CONTROL, (lfsr & 8'h11) | 8'h0E, q);
         rchk("ctl", KPW_ADDR_KEYPAD_CONTROL, exp_ctl(lfsr));
      end
      $display("control test done");
      // c: level, mask, global enable, wake enable, power-down
      for (int k = 0; k < 40; k++) begin
         lfsr = next_rand(lfsr);
         c = (k < 32) ? k[4:0] : lfsr[4:0];
         act_hi = c[0];
         gen = c[2];
         pd = c[4];
         bus(1'h1, KPW_ADDR_KEYPAD_CONTROL, {3'h0, c[0], 3'h7, c[1]}, q);
         bus(1'h1, KPW_ADDR_KEYPAD_STATUS, {c[3], 7'h00}, q);
         repeat (4) @(negedge clk);
         bus(1'h0, KPW_ADDR_KEYPAD_STATUS, 8'h00, q);
         @(negedge clk);
         `CHK("irq idle", 1'h0, irq)
         press = 1'h1;
         repeat (6) @(negedge clk);
         `CHK("irq", c[2] & !c[1], irq)
         `CHK("idle wake", c[2] & !c[1] & !c[4], idle_wake)
         `CHK("pd wake", c[4] & c[3] & c[2] & !c[1], pd_wake)
         press = 1'h0;
         repeat (4) @(negedge clk);
         pd = c[4];
         rchk("sta", KPW_ADDR_KEYPAD_STATUS, {c[3], 7'h01});
         rchk("sta", KPW_ADDR_KEYPAD_STATUS, {c[3], 7'h00});
      end
      $display("detect test done");
      report_and_stop();
   end
endmodule
